/* shared/tcv_defines.vh */
`ifndef TCV_DEFINES_VH
`define TCV_DEFINES_VH

// Channel value byte offsets, high byte then low byte
`define TCV_CH0_HI 8'h27
`define TCV_CH0_LO 8'h28
`define TCV_CH1_HI 8'h2a
`define TCV_CH1_LO 8'h2b
`define TCV_CH2_HI 8'h2d
`define TCV_CH2_LO 8'h2e
`define TCV_CH3_HI 8'h30
`define TCV_CH3_LO 8'h31
`define TCV_CH4_HI 8'h33
`define TCV_CH4_LO 8'h34
`define TCV_CH5_HI 8'h36
`define TCV_CH5_LO 8'h37

// Channel control bytes sit at base plus channel number
`define TCV_CTRL_BASE 8'h40
`define TCV_CTRL_LAST 8'h45
// Interrupt status (write one to clear) and mask
`define TCV_IRQ_STAT 8'h46
`define TCV_IRQ_MASK 8'h47

// Channel control field positions
`define TCV_F_MAXDUTY 0
`define TCV_F_TOV 1
`define TCV_F_ELS_LO 2
`define TCV_F_ELS_HI 3
`define TCV_F_MODE_A 4
`define TCV_F_MODE_B 5
`define TCV_F_FLAG 7
`define TCV_CTRL_WMASK 6'h3f

// Edge and level select encodings
`define TCV_ELS_OFF 2'h0
`define TCV_ELS_TOGGLE 2'h1
`define TCV_ELS_CLEAR 2'h2
`define TCV_ELS_SET 2'h3

// Reset values
`define TCV_CTRL_RST 6'h00
`define TCV_IRQ_RST 6'h00
`define TCV_RDATA_RST 8'h00

`endif

/* src/tcv_edge.v */
`timescale 1ns/1ns
`include "tcv_defines.vh"
module tcv_edge (
  // Clock and control
  input wire i_clk,
  input wire i_rst,
  input wire i_ce,
  // Capture pin and edge select
  input wire i_pin,
  input wire [1:0] i_els,
  // One-cycle active edge
  output wire o_hit
);
  reg pin_prev_ff;

  // Remember last pin level for edge detection
  always @(posedge i_clk) begin
    if (i_rst) begin
      pin_prev_ff <= 1'b0;
    end else if (i_ce) begin
      pin_prev_ff <= i_pin;
    end
  end

  // Rising edge on select bit 0, falling edge on select bit 1
  assign o_hit = i_ce & ((i_els[0] & i_pin & ~pin_prev_ff) |
                         (i_els[1] & ~i_pin & pin_prev_ff));
endmodule

/* src/tcv_irq.v */
`timescale 1ns/1ns
`include "tcv_defines.vh"
module tcv_irq (
  // Clock and control
  input wire i_clk,
  input wire i_rst,
  input wire i_ce,
  // Channel events and software access
  input wire [5:0] i_set,
  input wire i_stat_wr,
  input wire i_mask_wr,
  input wire [5:0] i_wdata,
  // State and interrupt line
  output wire [5:0] o_status,
  output wire [5:0] o_mask,
  output wire o_irq
);
  reg [5:0] status_ff;
  reg [5:0] mask_ff;
  reg irq_ff;
  wire [5:0] nxt_status;

  // Set wins over a write-one clear in the same cycle
  assign nxt_status = (status_ff & ~(i_stat_wr ? i_wdata : 6'h00)) | i_set;

  // Sticky status, mask and registered level interrupt
  always @(posedge i_clk) begin
    if (i_rst) begin
      status_ff <= `TCV_IRQ_RST;
      mask_ff <= `TCV_IRQ_RST;
      irq_ff <= 1'b0;
    end else if (i_ce) begin
      status_ff <= nxt_status;
      if (i_mask_wr) begin
        mask_ff <= i_wdata;
      end
      irq_ff <= |(nxt_status & (i_mask_wr ? i_wdata : mask_ff));
    end
  end

  assign o_status = status_ff;
  assign o_mask = mask_ff;
  assign o_irq = irq_ff;
endmodule

/* src/tcv_top.v */
`timescale 1ns/1ns
`include "tcv_defines.vh"
// Overview of operation
// - With toggle-on-overflow clear, max duty forces full output duty.
// - Max duty set or cleared takes effect only in the next period.
// - Each channel has a 16-bit RW value: high byte 15..8, low 7..0.
// - Channel values have no reset and start undefined.
// - In capture mode a high byte read blocks captures until low is read.
// - Compare mode: high write holds off match and flag until low write.
// - The event flag sets on an active capture edge or a compare match.
// - With toggle-on-overflow an overflow toggles output, beating a match.
// - With an edge selected and mode select B clear, mode select A picks capture 0, compare 1; B set is compare.
module tcv_top (
  // Clock, reset and clock enable
  input wire i_clk,
  input wire i_rst,
  input wire i_ce,
  // Register port
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output wire [7:0] o_rdata,
  // Timer counter
  input wire [15:0] i_count,
  input wire i_overflow,
  // Capture inputs
  input wire [5:0] i_cap_pin,
  // Channel outputs and events
  output wire [5:0] o_chan_out,
  output wire [5:0] o_channel_event_flag,
  output wire o_irq
);
  reg [7:0] val_hi_ff [0:5];
  reg [7:0] val_lo_ff [0:5];
  reg [5:0] ctrl_ff [0:5];
  reg [5:0] cap_lock_ff;
  reg [5:0] cmp_lock_ff;
  reg [5:0] max_eff_ff;
  reg [5:0] out_ff;
  reg [7:0] rdata_ff;
  reg [7:0] nxt_rdata;
  reg [5:0] wr_hi;
  reg [5:0] wr_lo;
  reg [5:0] rd_hi;
  reg [5:0] rd_lo;
  reg [5:0] wr_ctrl;
  reg [5:0] chan_en;
  reg [5:0] cap_mode;
  reg [5:0] cmp_mode;
  reg [5:0] cap_ev;
  reg [5:0] match;
  wire [5:0] edge_hit;
  wire [5:0] status;
  wire [5:0] mask;
  wire stat_wr;
  wire mask_wr;
  // Loop indices, one per process so that none has two writers
  integer cd;
  integer cm;
  integer cv;
  integer ck;
  integer cx;
  integer co;
  integer cr;

  // High byte offset of a channel
  function [7:0] hi_addr;
    input integer ch;
    begin
      case (ch)
        0: hi_addr = `TCV_CH0_HI;
        1: hi_addr = `TCV_CH1_HI;
        2: hi_addr = `TCV_CH2_HI;
        3: hi_addr = `TCV_CH3_HI;
        4: hi_addr = `TCV_CH4_HI;
        default: hi_addr = `TCV_CH5_HI;
      endcase
    end
  endfunction

  // Low byte offset of a channel
  function [7:0] lo_addr;
    input integer ch;
    begin
      case (ch)
        0: lo_addr = `TCV_CH0_LO;
        1: lo_addr = `TCV_CH1_LO;
        2: lo_addr = `TCV_CH2_LO;
        3: lo_addr = `TCV_CH3_LO;
        4: lo_addr = `TCV_CH4_LO;
        default: lo_addr = `TCV_CH5_LO;
      endcase
    end
  endfunction

  // Capture mode: both mode bits clear and an edge selected
  function is_capture;
    input [5:0] ctl;
    begin
      is_capture = ~ctl[`TCV_F_MODE_B] & ~ctl[`TCV_F_MODE_A] &
                   (ctl[`TCV_F_ELS_HI:`TCV_F_ELS_LO] != `TCV_ELS_OFF);
    end
  endfunction

  // Compare or pulse-width mode: a mode bit set and an action selected
  function is_compare;
    input [5:0] ctl;
    begin
      is_compare = (ctl[`TCV_F_MODE_B] | ctl[`TCV_F_MODE_A]) &
                   (ctl[`TCV_F_ELS_HI:`TCV_F_ELS_LO] != `TCV_ELS_OFF);
    end
  endfunction

  // Control byte offset of a channel
  function [7:0] ctrl_addr;
    input integer ch;
    begin
      ctrl_addr = `TCV_CTRL_BASE + ch[7:0];
    end
  endfunction

  // Capture edge detectors, one per channel
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_edge
      tcv_edge u_edge (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_pin(i_cap_pin[g]),
        .i_els(ctrl_ff[g][`TCV_F_ELS_HI:`TCV_F_ELS_LO]),
        .o_hit(edge_hit[g])
      );
    end
  endgenerate

  // Register strobe decode per channel
  always @* begin
    for (cd = 0; cd < 6; cd = cd + 1) begin
      wr_hi[cd] = i_wr & (i_addr == hi_addr(cd));
      wr_lo[cd] = i_wr & (i_addr == lo_addr(cd));
      rd_hi[cd] = i_rd & (i_addr == hi_addr(cd));
      rd_lo[cd] = i_rd & (i_addr == lo_addr(cd));
      wr_ctrl[cd] = i_wr & (i_addr == ctrl_addr(cd));
    end
  end

  assign stat_wr = i_wr & (i_addr == `TCV_IRQ_STAT);
  assign mask_wr = i_wr & (i_addr == `TCV_IRQ_MASK);

  // Channel mode decode, capture events and compare matches
  always @* begin
    for (cm = 0; cm < 6; cm = cm + 1) begin
      // Buffered mode on an even channel takes over the odd partner
      if (cm % 2 == 1) begin
        chan_en[cm] = ~ctrl_ff[cm - 1][`TCV_F_MODE_B];
      end else begin
        chan_en[cm] = 1'b1;
      end
      cap_mode[cm] = chan_en[cm] & is_capture(ctrl_ff[cm]);
      cmp_mode[cm] = chan_en[cm] & is_compare(ctrl_ff[cm]);
      cap_ev[cm] = cap_mode[cm] & edge_hit[cm] &
                   ~cap_lock_ff[cm];
      match[cm] = cmp_mode[cm] & ~cmp_lock_ff[cm] &
                  (i_count == {val_hi_ff[cm], val_lo_ff[cm]});
    end
  end

  // Channel value bytes, left without reset
  always @(posedge i_clk) begin
    if (i_ce) begin
      for (cv = 0; cv < 6; cv = cv + 1) begin
        if (cap_ev[cv]) begin
          // Capture wins over a same-cycle software write
          val_hi_ff[cv] <= i_count[15:8];
          val_lo_ff[cv] <= i_count[7:0];
        end else begin
          if (wr_hi[cv]) begin
            val_hi_ff[cv] <= i_wdata;
          end
          if (wr_lo[cv]) begin
            val_lo_ff[cv] <= i_wdata;
          end
        end
      end
    end
  end

  // Control bytes and byte interlocks
  always @(posedge i_clk) begin
    if (i_rst) begin
      cap_lock_ff <= 6'h00;
      cmp_lock_ff <= 6'h00;
      for (ck = 0; ck < 6; ck = ck + 1) begin
        ctrl_ff[ck] <= `TCV_CTRL_RST;
      end
    end else if (i_ce) begin
      for (ck = 0; ck < 6; ck = ck + 1) begin
        if (wr_ctrl[ck]) begin
          ctrl_ff[ck] <= i_wdata[5:0] & `TCV_CTRL_WMASK;
          // Only even channels own a buffered mode bit
          if (ck % 2 == 1) begin
            ctrl_ff[ck][`TCV_F_MODE_B] <= 1'b0;
          end
        end
        // Reading the high byte freezes captures until low is read
        if (rd_lo[ck]) begin
          cap_lock_ff[ck] <= 1'b0;
        end else if (rd_hi[ck] & cap_mode[ck]) begin
          cap_lock_ff[ck] <= 1'b1;
        end
        // Writing the high byte holds off matches until low is written
        if (wr_lo[ck]) begin
          cmp_lock_ff[ck] <= 1'b0;
        end else if (wr_hi[ck] & cmp_mode[ck]) begin
          cmp_lock_ff[ck] <= 1'b1;
        end
      end
    end
  end

  // Max duty is sampled only at the period boundary
  always @(posedge i_clk) begin
    if (i_rst) begin
      max_eff_ff <= 6'h00;
    end else if (i_ce && i_overflow) begin
      for (cx = 0; cx < 6; cx = cx + 1) begin
        max_eff_ff[cx] <= ctrl_ff[cx][`TCV_F_MAXDUTY] &
                          ~ctrl_ff[cx][`TCV_F_TOV];
      end
    end
  end

  // Channel output level
  always @(posedge i_clk) begin
    if (i_rst) begin
      out_ff <= 6'h00;
    end else if (i_ce) begin
      for (co = 0; co < 6; co = co + 1) begin
        if (ctrl_ff[co][`TCV_F_ELS_HI:`TCV_F_ELS_LO] == `TCV_ELS_OFF) begin
          // Preset level: mode select A set means start low
          out_ff[co] <= ~ctrl_ff[co][`TCV_F_MODE_A];
        end else if (cmp_mode[co]) begin
          if (max_eff_ff[co]) begin
            out_ff[co] <= 1'b1;
          end else if (ctrl_ff[co][`TCV_F_TOV] & i_overflow) begin
            out_ff[co] <= ~out_ff[co];
          end else if (match[co]) begin
            case (ctrl_ff[co][`TCV_F_ELS_HI:`TCV_F_ELS_LO])
              `TCV_ELS_TOGGLE: out_ff[co] <= ~out_ff[co];
              `TCV_ELS_CLEAR: out_ff[co] <= 1'b0;
              `TCV_ELS_SET: out_ff[co] <= 1'b1;
              default: out_ff[co] <= out_ff[co];
            endcase
          end
        end
      end
    end
  end

  // Sticky event flags and interrupt line
  tcv_irq u_irq (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_set(cap_ev | match),
    .i_stat_wr(stat_wr),
    .i_mask_wr(mask_wr),
    .i_wdata(i_wdata[5:0]),
    .o_status(status),
    .o_mask(mask),
    .o_irq(o_irq)
  );

  // Read data mux; unmapped addresses read zero
  always @* begin
    nxt_rdata = `TCV_RDATA_RST;
    for (cr = 0; cr < 6; cr = cr + 1) begin
      if (i_addr == hi_addr(cr)) begin
        nxt_rdata = val_hi_ff[cr];
      end
      if (i_addr == lo_addr(cr)) begin
        nxt_rdata = val_lo_ff[cr];
      end
      if (i_addr == ctrl_addr(cr)) begin
        nxt_rdata = {status[cr], 1'b0, ctrl_ff[cr]};
      end
    end
    if (i_addr == `TCV_IRQ_STAT) begin
      nxt_rdata = {2'h0, status};
    end
    if (i_addr == `TCV_IRQ_MASK) begin
      nxt_rdata = {2'h0, mask};
    end
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge i_clk) begin
    if (i_rst) begin
      rdata_ff <= `TCV_RDATA_RST;
    end else if (i_ce) begin
      rdata_ff <= i_rd ? nxt_rdata : `TCV_RDATA_RST;
    end
  end

  assign o_rdata = rdata_ff;
  assign o_chan_out = out_ff;
  assign o_channel_event_flag = status;
endmodule

/* test/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  logic i_clk, i_rst, ovf, ce;
  logic [15:0] cnt, v;
  logic [7:0] b;
  logic [5:0] pin;
  wire [7:0] addr, wdata, rdata;
  wire wr, rd, irq;
  wire [5:0] cout, flag;
  int bad_count, check_count;
  // Bus clock
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  tcv_cpu_model i_cpu (.i_clk(i_clk), .o_addr(addr), .o_wdata(wdata),
    .o_wr(wr), .o_rd(rd), .i_rdata(rdata));
  tcv_top i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(ce), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_count(cnt), .i_overflow(ovf), .i_cap_pin(pin), .o_chan_out(cout),
    .o_channel_event_flag(flag), .o_irq(irq));
  // Compare and count
  task chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Counter value and overflow for one cycle, pin flips kept, then settle
  task tick(input logic [15:0] c, input logic o, input logic [5:0] p);
    cnt <= c;
    ovf <= o;
    pin <= pin ^ p;
    @(posedge i_clk);
    cnt <= 16'hfff0;
    ovf <= 1'b0;
    repeat (2) @(posedge i_clk);
  endtask
  task t_reset;
    chk(16'(cout), 16'h3f);
    chk(16'(irq), 16'h0);
    i_cpu.r8(8'h46, b);
    chk(16'(b), 16'h0);
    i_cpu.r8(8'h50, b);
    chk(16'(b), 16'h0);
    $display("t_reset done");
  endtask
  task t_regs;
    for (int c = 5; c > 0; c--) i_cpu.w16(8'h27 + 8'(3 * c), 16'(c));
    i_cpu.cyc(1'b1, 1'b0, 8'h27, 8'ha5);
    i_cpu.cyc(1'b1, 1'b0, 8'h28, 8'h3c);
    i_cpu.rd16(8'h27, v);
    chk(v, 16'ha53c);
    for (int c = 1; c < 6; c++) begin
      i_cpu.rd16(8'h27 + 8'(3 * c), v);
      chk(v, 16'(c));
    end
    $display("t_regs done");
  endtask
  task t_compare;
    i_cpu.cyc(1'b1, 1'b0, 8'h40, 8'h14);
    i_cpu.r8(8'h40, b);
    chk(16'(b), 16'h14);
    i_cpu.w8(8'h47, 8'h01);
    i_cpu.w16(8'h27, 16'h0100);
    tick(16'h0100, 1'b0, 6'h00);
    chk({cout[0], irq, 8'(flag)}, 16'h0101);
    i_cpu.w8(8'h46, 8'h01);
    chk({cout[0], irq, 8'(flag)}, 16'h0000);
    i_cpu.w8(8'h27, 8'h01);
    tick(16'h0100, 1'b0, 6'h00);
    chk({cout[0], irq, 8'(flag)}, 16'h0000);
    i_cpu.w8(8'h28, 8'h00);
    tick(16'h0100, 1'b0, 6'h00);
    chk({cout[0], irq, 8'(flag)}, 16'h0301);
    i_cpu.w8(8'h46, 8'h01);
    $display("t_compare done");
  endtask
  task t_capture;
    i_cpu.w8(8'h41, 8'h04);
    tick(16'h1234, 1'b0, 6'h02);
    i_cpu.rd16(8'h2a, v);
    chk(v, 16'h1234);
    chk(16'(flag[1]), 16'h1);
    i_cpu.r8(8'h2a, b);
    tick(16'h1111, 1'b0, 6'h02);
    tick(16'h5678, 1'b0, 6'h02);
    i_cpu.r8(8'h2b, b);
    chk(16'(b), 16'h34);
    tick(16'h1111, 1'b0, 6'h02);
    tick(16'h9abc, 1'b0, 6'h02);
    i_cpu.rd16(8'h2a, v);
    chk(v, 16'h9abc);
    $display("t_capture done");
  endtask
  task t_maxduty;
    i_cpu.w8(8'h42, 8'h18);
    i_cpu.w16(8'h2d, 16'h0200);
    tick(16'h0200, 1'b0, 6'h00);
    i_cpu.w8(8'h42, 8'h19);
    chk(16'(cout[2]), 16'h0);
    tick(16'hfff0, 1'b1, 6'h00);
    tick(16'h0200, 1'b0, 6'h00);
    chk(16'(cout[2]), 16'h1);
    i_cpu.w8(8'h42, 8'h18);
    tick(16'h0200, 1'b0, 6'h00);
    chk(16'(cout[2]), 16'h1);
    tick(16'hfff0, 1'b1, 6'h00);
    tick(16'h0200, 1'b0, 6'h00);
    chk(16'(cout[2]), 16'h0);
    $display("t_maxduty done");
  endtask
  task t_tov;
    i_cpu.w8(8'h43, 8'h1a);
    i_cpu.w16(8'h30, 16'h0300);
    tick(16'hfff0, 1'b1, 6'h00);
    chk(16'(cout[3]), 16'h0);
    tick(16'h0300, 1'b1, 6'h00);
    chk({cout[3], flag[3]}, 16'h3);
    $display("t_tov done");
  endtask
  // Both-edge capture, then buffered compare on ch4 disables ch5
  task t_buffer;
    i_cpu.w8(8'h45, 8'h0c);
    tick(16'h4321, 1'b0, 6'h20);
    tick(16'h8765, 1'b0, 6'h20);
    i_cpu.rd16(8'h36, v);
    chk(v, 16'h8765);
    i_cpu.w8(8'h44, 8'h24);
    tick(16'h0fff, 1'b0, 6'h20);
    tick(16'h0004, 1'b0, 6'h00);
    i_cpu.rd16(8'h36, v);
    chk(v, 16'h8765);
    chk({cout[4], flag[5:4]}, 16'h3);
    $display("t_buffer done");
  endtask
  // Clock enable low ignores a flag clear; high again, it takes
  task t_freeze;
    ce <= 1'b0;
    i_cpu.w8(8'h46, 8'h3f);
    ce <= 1'b1;
    chk(16'(flag), 16'h3e);
    i_cpu.w8(8'h46, 8'h3f);
    chk(16'(flag), 16'h00);
    $display("t_freeze done");
  endtask
  // Main sequence
  initial begin
    i_rst = 1'b1;
    ce = 1'b1;
    ovf = 1'b0;
    cnt = 16'hfff0;
    pin = 6'h00;
    bad_count = 0;
    check_count = 0;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (2) @(posedge i_clk);
    t_reset;
    t_regs;
    t_compare;
    t_capture;
    t_maxduty;
    t_tov;
    t_buffer;
    t_freeze;
    print_verdict;
  end
  // Hang guard
  initial begin
    repeat (4000) @(posedge i_clk);
    bad_count++;
    print_verdict;
  end
endmodule

/* test/tcv_asserts.sv */
`timescale 1ns/1ns
module tcv_asserts (
  // Clock and register port
  input wire i_clk,
  input wire i_rst,
  input wire i_ce,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [7:0] o_rdata,
  // Timer side
  input wire [15:0] i_count,
  input wire i_overflow,
  input wire [5:0] i_cap_pin,
  input wire [5:0] o_chan_out,
  input wire [5:0] o_channel_event_flag,
  input wire o_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Short name for the sticky status bits
  wire [5:0] flg;
  assign flg = o_channel_event_flag;

  a_rdata_idle: assert property (
    !$past(i_rd) |-> o_rdata == 8'h00) else $error("stray read data");
  a_unmapped_read: assert property (
    i_rd && i_addr == 8'h50 |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_value_readback: assert property (
    i_wr && i_addr == 8'h27 ##1 i_wr && i_addr == 8'h28
    ##1 i_rd && i_addr == 8'h27 |=> o_rdata == $past(i_wdata, 3))
    else $error("value high byte lost");
  a_ctrl_readback: assert property (
    i_wr && i_addr == 8'h40 ##1 i_rd && i_addr == 8'h40
    |=> o_rdata[5:0] == $past(i_wdata[5:0], 2))
    else $error("control readback wrong");
  a_flag_sticky: assert property (
    !(i_wr && i_addr == 8'h46) |=> (flg & $past(flg)) == $past(flg))
    else $error("event flag dropped");
  a_irq_no_flag: assert property (
    flg == 6'h00 |-> !o_irq) else $error("irq without flag");
  a_irq_rise: assert property (
    $rose(o_irq) |-> $past(i_wr && i_addr == 8'h47) || flg != $past(flg))
    else $error("irq rose without cause");
  a_reset_clear: assert property (
    @(posedge i_clk) disable iff (1'b0)
    i_rst |=> o_rdata == 8'h00 && flg == 6'h00 && !o_irq)
    else $error("reset left state");

  c_flag: cover property ($rose(flg[0]));
  c_irq: cover property ($rose(o_irq));
  c_ovf: cover property (i_overflow ##1 o_chan_out != $past(o_chan_out));
endmodule

bind tcv_top tcv_asserts u_chk (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .i_count(i_count), .i_overflow(i_overflow),
  .i_cap_pin(i_cap_pin), .o_chan_out(o_chan_out),
  .o_channel_event_flag(o_channel_event_flag), .o_irq(o_irq));

/* test/tcv_cpu_model.sv */
`timescale 1ns/1ns
module tcv_cpu_model (
  // Bus clock
  input wire i_clk,
  // Register port toward the block
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_wr,
  output logic o_rd,
  input wire [7:0] i_rdata
);
  // Port idle at start
  initial begin
    o_addr = 8'h00;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  // One bus cycle, signals held until the next call
  task cyc(input logic w, input logic r, input logic [7:0] a,
    input logic [7:0] d);
    o_wr <= w;
    o_rd <= r;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clk);
  endtask
  // Byte write then idle
  task w8(input logic [7:0] a, input logic [7:0] d);
    cyc(1'b1, 1'b0, a, d);
    cyc(1'b0, 1'b0, 8'h00, 8'h00);
  endtask
  // Byte read, data taken in the cycle after the strobe
  task r8(input logic [7:0] a, output logic [7:0] d);
    cyc(1'b0, 1'b1, a, 8'h00);
    cyc(1'b0, 1'b0, 8'h00, 8'h00);
    d = i_rdata;
  endtask
  // Value write, high byte first to release the compare lock
  task w16(input logic [7:0] a, input logic [15:0] v);
    cyc(1'b1, 1'b0, a, v[15:8]);
    w8(a + 8'h01, v[7:0]);
  endtask
  // Value read, high byte first to release the capture lock
  task rd16(input logic [7:0] a, output logic [15:0] v);
    cyc(1'b0, 1'b1, a, 8'h00);
    cyc(1'b0, 1'b1, a + 8'h01, 8'h00);
    v[15:8] = i_rdata;
    cyc(1'b0, 1'b0, 8'h00, 8'h00);
    v[7:0] = i_rdata;
  endtask
endmodule
